// >>> sim/cct_props.sv
// Checker on the shared trigger bus and the device bus handshake.
// Assumes one clock; the bench places it beside the interface.
`timescale 1ns/100ps
module cct_props (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic dev_trig_oe,
	input wire logic far_trig_oe,
	input wire logic dev_bnc_oe,
	input wire logic far_bnc_oe,
	input wire logic dev_rdy_oe,
	input wire logic far_rdy_oe,
	input wire logic dev_exec_oe,
	input wire logic far_exec_oe,
	input wire logic trig_n,
	input wire logic bnc_trig_n,
	input wire logic ready,
	input wire logic exec_n,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic o_waitrequest,
	input wire logic o_break,
	input wire logic o_trace_started
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);
	// Request pending and not yet answered
	sequence req_wait;
		(i_read || i_write) && o_waitrequest;
	endsequence
	// Execute was seen low two to four edges back
	sequence exec_back;
		!$past(exec_n, 2) || !$past(exec_n, 3) || !$past(exec_n, 4);
	endsequence
	// Wire levels, handshake, reset state and execute sync
	a_trig_wire: assert property (trig_n == !(dev_trig_oe || far_trig_oe))
		else $error("trigger wire level wrong");
	a_bnc_wire: assert property (bnc_trig_n == !(dev_bnc_oe || far_bnc_oe))
		else $error("coax trigger level wrong");
	a_ready_wire: assert property (ready == !(dev_rdy_oe || far_rdy_oe))
		else $error("ready wire level wrong");
	a_exec_wire: assert property (exec_n == !(dev_exec_oe || far_exec_oe))
		else $error("execute wire level wrong");
	a_wait_answer: assert property (req_wait |=> !o_waitrequest)
		else $error("request not answered in one cycle");
	a_wait_one: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("answer stood more than one cycle");
	a_reset_idle: assert property ($rose(i_rstn) |-> o_waitrequest &&
		!o_break && !(dev_trig_oe || dev_bnc_oe || dev_rdy_oe || dev_exec_oe))
		else $error("device not idle after reset");
	a_exec_sync: assert property ($rose(o_trace_started) |-> exec_back)
		else $error("trace start not tied to synced execute");
endmodule : cct_props

// >>> sim/tb_coordinated_cross_trigger.sv
// Bench joining the device end and the far end over the shared bus.
// Assumes a 25 MHz clock; qualifier limits shortened by parameter.
`timescale 1ns/100ps
module tb_coordinated_cross_trigger;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic rd = 1'b0;
	logic we = 1'b0;
	logic [2:0] adr = 3'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata, rq;
	logic wreq, brk, xrun, tstart, f_trig;
	logic [15:0] probe = 16'h0;
	logic [15:0] mask, val;
	logic emu_trig = 1'b0;
	logic [3:0] freq = 4'h0;
	logic [31:0] rnd = 32'h6ADD26BA;
	logic [31:0] mdl [8];
	int n_mismatch = 0;
	int checks = 0;
	int n_ts = 0;
	int n_run = 0;
	int n_ftrig = 0;
	cct_if bus ();
	cct_dev #(.P_GT_MAX_CYC(64), .P_LT_MAX_CYC(32)) cct_dev_inst (
		.i_mclk(mclk), .i_rstn(rstn), .i_ce(1'b1), .bus(bus.dev),
		.i_address(adr), .i_read(rd), .i_write(we), .i_writedata(wd),
		.o_readdata(rdata), .o_waitrequest(wreq), .i_probe(probe),
		.i_emu_an_trig(emu_trig), .o_break(brk), .o_exec_run(xrun),
		.o_trace_started(tstart)
	);
	cct_far cct_far_inst (
		.i_mclk(mclk), .i_rstn(rstn), .i_ce(1'b1), .bus(bus.far),
		.i_trig_req(freq[0]), .i_bnc_req(freq[1]),
		.i_ready_hold(freq[2]), .i_exec_req(freq[3]),
		.o_trig(f_trig), .o_bnc(), .o_ready(), .o_exec()
	);
	cct_props cct_props_inst (
		.i_mclk(mclk), .i_rstn(rstn),
		.dev_trig_oe(bus.dev_trig_oe), .far_trig_oe(bus.far_trig_oe),
		.dev_bnc_oe(bus.dev_bnc_oe), .far_bnc_oe(bus.far_bnc_oe),
		.dev_rdy_oe(bus.dev_rdy_oe), .far_rdy_oe(bus.far_rdy_oe),
		.dev_exec_oe(bus.dev_exec_oe), .far_exec_oe(bus.far_exec_oe),
		.trig_n(bus.trig_n), .bnc_trig_n(bus.bnc_trig_n),
		.ready(bus.ready), .exec_n(bus.exec_n), .i_read(rd), .i_write(we),
		.o_waitrequest(wreq), .o_break(brk), .o_trace_started(tstart)
	);
	// Clock
	always #20 mclk = ~mclk;
	// Counts output pulses and far-end trigger sightings
	always @(posedge mclk) begin
		if (tstart === 1'b1) n_ts <= n_ts + 1;
		if (xrun === 1'b1) n_run <= n_run + 1;
		if (f_trig === 1'b1) n_ftrig <= n_ftrig + 1;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One bus transfer, held until waitrequest is sampled low
	task automatic xfer(input logic w, input logic [2:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		rd <= !w;
		we <= w;
		@(posedge mclk);
		while (wreq !== 1'b0 && n < 20) begin
			n++;
			@(posedge mclk);
		end
		if (n == 20) begin
			n_mismatch++;
			final_report();
		end
		rq = rdata;
		rd <= 1'b0;
		we <= 1'b0;
		@(posedge mclk);
	endtask : xfer
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		mdl[a] = d;
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [2:0] a, input logic [31:0] m,
		input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rq & m, e);
	endtask : rdc
	// Break is a held level, so it is looked at after a short settle
	task automatic brk_is(input logic e);
		repeat (8) @(posedge mclk);
		chk({31'h0, brk}, {31'h0, e});
	endtask : brk_is
	// Pattern held k cycles with random ignored channels, then broken
	task automatic drive(input int k);
		repeat (k) begin
			rnd = lfsr_next(rnd);
			probe <= (val & mask) | (rnd[15:0] & ~mask);
			@(posedge mclk);
		end
		probe <= {val[15:1], ~val[0]};
	endtask : drive
	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		final_report();
	end
	// Main sequence
	initial begin
		int lt [4] = '{2, 5, 6, 9};
		logic [31:0] rt [3] = '{32'h011, 32'h014, 32'h018};
		logic [31:0] ct [3] = '{32'h0E, 32'h08, 32'h1A};
		int b0, b1;
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rdc(cct_pkg::REG_CTRL, 32'hFFFFFFFF, {26'h0, cct_pkg::CTRL_RST});
		rdc(cct_pkg::REG_ROUTE_A, 32'hFFFFFFFF, 32'h0);
		rdc(cct_pkg::REG_STATUS, 32'h10C0, 32'h10C0);
		wr(3'h7, 32'hFFFFFFFF);
		rdc(3'h7, 32'hFFFFFFFF, 32'h0);
		rdc(cct_pkg::REG_COMMAND, 32'hFFFFFFFF, 32'h0);
		$display("test registers done");
		rnd = lfsr_next(rnd);
		mask = rnd[15:0] | 16'h0001;
		val = rnd[31:16];
		probe <= {val[15:1], ~val[0]};
		wr(cct_pkg::REG_ROUTE_A, 32'h092);
		wr(cct_pkg::REG_PATTERN, {val, mask});
		wr(cct_pkg::REG_DURATION, 32'h5);
		rdc(cct_pkg::REG_PATTERN, 32'hFFFFFFFF, mdl[3]);
		wr(cct_pkg::REG_COMMAND, 32'h1);
		drive(4);
		brk_is(1'b0);
		drive(12);
		brk_is(1'b1);
		chk(32'(n_ftrig > 0), 32'h1);
		chk({31'h0, bus.trig_n}, 32'h1);
		rdc(cct_pkg::REG_STATUS, 32'h12, 32'h12);
		wr(cct_pkg::REG_COMMAND, 32'h10);
		brk_is(1'b0);
		wr(cct_pkg::REG_COMMAND, 32'h1);
		wr(cct_pkg::REG_COMMAND, 32'h2);
		drive(12);
		brk_is(1'b0);
		$display("test greater-than done");
		wr(cct_pkg::REG_DURATION, 32'h80000006);
		foreach (lt[i]) begin
			wr(cct_pkg::REG_COMMAND, 32'h1);
			drive(lt[i]);
			brk_is(lt[i] < 6);
			wr(cct_pkg::REG_COMMAND, 32'h10);
		end
		$display("test less-than done");
		wr(cct_pkg::REG_ROUTE_A, 32'h0);
		for (int j = 0; j < 3; j++) begin
			wr(cct_pkg::REG_ROUTE_B, rt[j]);
			if (j == 0) wr(cct_pkg::REG_COMMAND, 32'h4);
			emu_trig <= (j == 0);
			freq <= {2'b0, j == 2, j == 1};
			brk_is(1'b1);
			emu_trig <= 1'b0;
			freq <= 4'h0;
			// Let the released line clear the synchroniser before run
			repeat (3) @(posedge mclk);
			wr(cct_pkg::REG_COMMAND, 32'h10);
			brk_is(1'b0);
		end
		$display("test trigger routes done");
		wr(cct_pkg::REG_ROUTE_B, 32'h0);
		for (int j = 0; j < 3; j++) begin
			wr(cct_pkg::REG_CTRL, ct[j]);
			rdc(cct_pkg::REG_CTRL, 32'hFFFFFFFF, mdl[0]);
			b0 = n_ts;
			b1 = n_run;
			freq <= 4'h8;
			@(posedge mclk);
			freq <= 4'h0;
			repeat (10) @(posedge mclk);
			chk(32'(n_ts - b0), 32'(j == 0));
			chk(32'(n_run - b1), 32'(j == 2));
		end
		rdc(cct_pkg::REG_STATUS, 32'h20, 32'h20);
		wr(cct_pkg::REG_COMMAND, 32'h40);
		rdc(cct_pkg::REG_STATUS, 32'h20, 32'h0);
		$display("test execute done");
		for (int j = 0; j < 3; j++) begin
			wr(cct_pkg::REG_CTRL, ct[j] == 32'h0E ? 32'h09 : ct[j] - 32'h7);
			freq <= 4'h4;
			brk_is(j == 0);
			freq <= 4'h0;
			// Ready must be seen high again before the run release
			repeat (3) @(posedge mclk);
			wr(cct_pkg::REG_COMMAND, 32'h10);
			brk_is(1'b0);
		end
		$display("test ready done");
		final_report();
	end
endmodule : tb_coordinated_cross_trigger

// >>> verilog/cct_dev.sv
// Emulator end: cross-trigger routing, run control and timing qualifier.
// Assumes Avalon-MM software access and synchronous probe inputs.
`timescale 1ns/100ps
// How it works
// - Trigger lines low-true, bus and coax alike
// - Trigger drives out, arms, or breaks emulator
// - Ready low forces break while run control on
// - Execute low-true global interrupt, preset action
// - Begin-on-execute starts trace, reports start
// - Two cross-trigger lines, each routed separately
// - Routed analyzer trigger breaks the emulator
// - First analyzer to trigger drives shared line
// - Pattern is AND of low/high/ignore channels
// - Failed pattern waits reset interval, searches again
// - Greater-than fires after programmed hold time
// - Less-than fires on short valid pattern
// - Host begin and halt obeyed at once
// - Coordination only with background monitor
// - Three bus lines, each only when enabled
// - Breaking analyzer stops driving its line
// - Analyzer armed unless a line arms it
module cct_dev #(
	parameter int P_GT_MAX_CYC = cct_pkg::GT_MAX_CYC,
	parameter int P_LT_MAX_CYC = cct_pkg::LT_MAX_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_ce,
	cct_if.dev bus,
	input wire logic [2:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	input wire logic [15:0] i_probe,
	input wire logic i_emu_an_trig,
	output logic o_break,
	output logic o_exec_run,
	output logic o_trace_started
);
	// Limit a programmed duration to the legal span of its mode
	function automatic logic [cct_pkg::DUR_W-1:0] dur_clamp(
		input logic [cct_pkg::DUR_W-1:0] v, input logic lt);
		logic [cct_pkg::DUR_W-1:0] lo, hi;
		lo = lt ? cct_pkg::DUR_W'(cct_pkg::LT_MIN_CYC)
			: cct_pkg::DUR_W'(cct_pkg::GT_MIN_CYC);
		hi = lt ? cct_pkg::DUR_W'(P_LT_MAX_CYC)
			: cct_pkg::DUR_W'(P_GT_MAX_CYC);
		dur_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : dur_clamp

	logic [cct_pkg::N_LN-1:0] s1_q, s2_q, s1_d;
	logic wreq_q, wreq_d;
	logic [31:0] rdata_q, rdata_d;
	logic [cct_pkg::CTL_W-1:0] ctrl_q, ctrl_d;
	logic [cct_pkg::RT_W-1:0] route_q [2];
	logic [cct_pkg::RT_W-1:0] route_d [2];
	logic [15:0] mask_q, mask_d, val_q, val_d;
	logic [cct_pkg::DUR_W-1:0] dur_q, dur_d, cnt_q, cnt_d, lim;
	logic ltm_q, ltm_d;
	cct_pkg::cct_tq_state_t st_q, st_d;
	logic emu_run_q, emu_run_d, emu_trig_q, emu_trig_d;
	logic brk_q, brk_d, exs_q, exs_d, exec_prev_q;
	logic [1:0] drop_q, drop_d, arm_q, arm_d, line;
	logic [3:0] pin_q, pin_d;
	logic exrun_q, exrun_d, tstart_q, tstart_d;
	logic acc, wr_acc, bg, hit, ext_trig, ext_armed, emu_armed;
	logic exec_ev, exec_beg, ext_beg, emu_beg, run_req;
	logic [31:0] cmd;

	// Two-stage synchronisers; logic reads only the second stage
	always_comb begin
		s1_d = {~bus.exec_n, bus.ready, ~bus.bnc_trig_n, ~bus.trig_n};
	end

	// Register bus answers after one wait cycle; unmapped reads zero
	always_comb begin
		acc = (i_read | i_write) & wreq_q;
		wr_acc = i_write & ~wreq_q;
		wreq_d = ~acc;
		rdata_d = rdata_q;
		if (acc) begin
			if (i_address == cct_pkg::REG_CTRL) begin
				rdata_d = {26'h0, ctrl_q};
			end else if (i_address == cct_pkg::REG_ROUTE_A) begin
				rdata_d = {23'h0, route_q[0]};
			end else if (i_address == cct_pkg::REG_ROUTE_B) begin
				rdata_d = {23'h0, route_q[1]};
			end else if (i_address == cct_pkg::REG_PATTERN) begin
				rdata_d = {val_q, mask_q};
			end else if (i_address == cct_pkg::REG_DURATION) begin
				rdata_d = {ltm_q, 11'h0, dur_q};
			end else if (i_address == cct_pkg::REG_STATUS) begin
				// Arm bits show the effective armed state of each analyzer
				rdata_d = {18'h0, s2_q, line, emu_armed, ext_armed, exs_q, brk_q,
					emu_trig_q, emu_run_q, ext_trig, st_q != cct_pkg::TQ_IDLE};
			end else begin
				rdata_d = 32'h0;
			end
		end
		cmd = (wr_acc && i_address == cct_pkg::REG_COMMAND)
			? i_writedata : 32'h0;
	end

	// Cross-trigger lines, arming, break and run decisions
	always_comb begin
		bg = ctrl_q[cct_pkg::CTL_BGMON]; // Coordination off otherwise
		ext_trig = (st_q == cct_pkg::TQ_DONE);
		for (int k = 0; k < 2; k++) begin
			// Either analyzer may drive; whichever fires first sets it
			line[k] = bg & ((route_q[k][cct_pkg::RT_SRC_EMU] & emu_trig_q
				| route_q[k][cct_pkg::RT_SRC_EXT] & ext_trig) & ~drop_q[k]
				| route_q[k][cct_pkg::RT_SRC_CMB] & s2_q[cct_pkg::LN_TRIG]
				| route_q[k][cct_pkg::RT_SRC_BNC] & s2_q[cct_pkg::LN_BNC]);
		end
		// Arming needed only when a line is routed to the analyzer
		emu_armed = arm_q[0] | ~(route_q[0][cct_pkg::RT_DST_EMU]
			| route_q[1][cct_pkg::RT_DST_EMU]);
		ext_armed = arm_q[1] | ~(route_q[0][cct_pkg::RT_DST_EXT]
			| route_q[1][cct_pkg::RT_DST_EXT]);
		// Execute acts only when enabled
		exec_ev = bg & ctrl_q[cct_pkg::CTL_EXEC]
			& s2_q[cct_pkg::LN_EXEC] & ~exec_prev_q;
		exec_beg = exec_ev & ctrl_q[cct_pkg::CTL_BEGEXEC];
		ext_beg = cmd[cct_pkg::CMD_EXT_BEGIN];
		emu_beg = cmd[cct_pkg::CMD_EMU_BEGIN] | exec_beg;
		run_req = cmd[cct_pkg::CMD_RUN]
			| exec_ev & ctrl_q[cct_pkg::CTL_EXECRUN];
		arm_d[0] = ~emu_beg & arm_q[0] | |(line & {route_q[1]
			[cct_pkg::RT_DST_EMU], route_q[0][cct_pkg::RT_DST_EMU]});
		arm_d[1] = ~ext_beg & arm_q[1] | |(line & {route_q[1]
			[cct_pkg::RT_DST_EXT], route_q[0][cct_pkg::RT_DST_EXT]});
		drop_d = drop_q;
		for (int k = 0; k < 2; k++) begin
			// The analyzer that caused the break lets go of its line
			if (route_q[k][cct_pkg::RT_DST_BRK] && line[k] && !brk_q
				&& (route_q[k][cct_pkg::RT_SRC_EMU] && emu_trig_q
				|| route_q[k][cct_pkg::RT_SRC_EXT] && ext_trig))
				drop_d[k] = 1'b1;
			if (emu_beg || ext_beg)
				drop_d[k] = 1'b0;
		end
		// Break sources win over a release in the same cycle
		brk_d = brk_q & ~run_req;
		if (|(line & {route_q[1][cct_pkg::RT_DST_BRK],
			route_q[0][cct_pkg::RT_DST_BRK]}))
			brk_d = 1'b1;
		if (bg && ctrl_q[cct_pkg::CTL_RUNCTL] && !s2_q[cct_pkg::LN_RDY])
			brk_d = 1'b1;
		emu_run_d = (emu_run_q | emu_beg) & ~cmd[cct_pkg::CMD_EMU_HALT];
		emu_trig_d = ~emu_beg & (emu_trig_q
			| emu_run_q & emu_armed & i_emu_an_trig);
		exs_d = exs_q & ~cmd[cct_pkg::CMD_CLR] | exec_beg;
		exrun_d = run_req;
		tstart_d = exec_beg; // Reports the trace start
		// Outward lines, active low; trigger and coax driven when routed, ready by control, execute by command
		pin_d[0] = |(line & {route_q[1][cct_pkg::RT_DST_CMB],
			route_q[0][cct_pkg::RT_DST_CMB]});
		pin_d[1] = |(line & {route_q[1][cct_pkg::RT_DST_BNC],
			route_q[0][cct_pkg::RT_DST_BNC]});
		pin_d[2] = bg & ctrl_q[cct_pkg::CTL_HOLDRDY];
		pin_d[3] = bg & cmd[cct_pkg::CMD_EXEC];
	end

	// Configuration writes
	always_comb begin
		ctrl_d = ctrl_q;
		route_d = route_q;
		mask_d = mask_q;
		val_d = val_q;
		dur_d = dur_q;
		ltm_d = ltm_q;
		if (wr_acc) begin
			if (i_address == cct_pkg::REG_CTRL) begin
				ctrl_d = i_writedata[cct_pkg::CTL_W-1:0];
			end else if (i_address == cct_pkg::REG_ROUTE_A) begin
				route_d[0] = i_writedata[cct_pkg::RT_W-1:0];
			end else if (i_address == cct_pkg::REG_ROUTE_B) begin
				route_d[1] = i_writedata[cct_pkg::RT_W-1:0];
			end else if (i_address == cct_pkg::REG_PATTERN) begin
				mask_d = i_writedata[15:0];
				val_d = i_writedata[31:16];
			end else if (i_address == cct_pkg::REG_DURATION) begin
				ltm_d = i_writedata[cct_pkg::DUR_LT];
				dur_d = dur_clamp(i_writedata[cct_pkg::DUR_W-1:0],
					i_writedata[cct_pkg::DUR_LT]);
			end
		end
	end

	// Timing qualifier: pattern match then duration test
	always_comb begin
		hit = &(~mask_q | ~(i_probe ^ val_q)); // Set mask bit cares
		lim = dur_q;
		st_d = st_q;
		cnt_d = cnt_q;
		case (st_q)
			cct_pkg::TQ_SEARCH: begin
				if (hit && ext_armed) begin
					st_d = cct_pkg::TQ_HOLD;
					cnt_d = cct_pkg::DUR_W'(1);
				end
			end
			cct_pkg::TQ_HOLD: begin
				if (hit) begin
					if (cnt_q >= lim)
						st_d = ltm_q ? cct_pkg::TQ_WAITEND
							: cct_pkg::TQ_DONE;
					else
						cnt_d = cnt_q + 1'b1;
				end else if (ltm_q && cnt_q >= cct_pkg::DUR_W'(
					cct_pkg::LT_VALID_CYC) && cnt_q < lim) begin
					st_d = cct_pkg::TQ_DONE;
				end else begin
					st_d = cct_pkg::TQ_RESET;
					cnt_d = '0;
				end
			end
			cct_pkg::TQ_WAITEND: begin
				if (!hit) begin
					st_d = cct_pkg::TQ_RESET;
					cnt_d = '0;
				end
			end
			cct_pkg::TQ_RESET: begin
				cnt_d = cnt_q + 1'b1; // Reset interval before a new search
				if (cnt_d >= cct_pkg::DUR_W'(cct_pkg::RST_CYC))
					st_d = cct_pkg::TQ_SEARCH;
			end
			default: begin
				st_d = st_q;
			end
		endcase
		// Host begin and halt take effect on the next edge
		if (ext_beg) begin
			st_d = cct_pkg::TQ_SEARCH;
			cnt_d = '0;
		end else if (cmd[cct_pkg::CMD_EXT_HALT]) begin
			st_d = cct_pkg::TQ_IDLE;
		end
	end

	// All state registers, frozen while the clock enable is low
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			s1_q <= 4'h4;
			s2_q <= 4'h4;
			wreq_q <= 1'b1;
			rdata_q <= 32'h0;
			ctrl_q <= cct_pkg::CTRL_RST;
			route_q[0] <= cct_pkg::ROUTE_RST;
			route_q[1] <= cct_pkg::ROUTE_RST;
			mask_q <= 16'h0;
			val_q <= 16'h0;
			dur_q <= cct_pkg::DUR_RST;
			ltm_q <= 1'b0;
			st_q <= cct_pkg::TQ_IDLE;
			cnt_q <= '0;
			emu_run_q <= 1'b0;
			emu_trig_q <= 1'b0;
			brk_q <= 1'b0;
			exs_q <= 1'b0;
			exec_prev_q <= 1'b0;
			drop_q <= 2'b00;
			arm_q <= 2'b00;
			pin_q <= 4'h0;
			exrun_q <= 1'b0;
			tstart_q <= 1'b0;
		end else if (i_ce) begin
			s1_q <= s1_d;
			s2_q <= s1_q;
			wreq_q <= wreq_d;
			rdata_q <= rdata_d;
			ctrl_q <= ctrl_d;
			route_q <= route_d;
			mask_q <= mask_d;
			val_q <= val_d;
			dur_q <= dur_d;
			ltm_q <= ltm_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			emu_run_q <= emu_run_d;
			emu_trig_q <= emu_trig_d;
			brk_q <= brk_d;
			exs_q <= exs_d;
			exec_prev_q <= s2_q[cct_pkg::LN_EXEC];
			drop_q <= drop_d;
			arm_q <= arm_d;
			pin_q <= pin_d;
			exrun_q <= exrun_d;
			tstart_q <= tstart_d;
		end
	end

	// Open-drain pins pull low only
	assign bus.dev_trig_o = 1'b0;
	assign bus.dev_trig_oe = pin_q[0];
	assign bus.dev_bnc_o = 1'b0;
	assign bus.dev_bnc_oe = pin_q[1];
	assign bus.dev_rdy_o = 1'b0;
	assign bus.dev_rdy_oe = pin_q[2];
	assign bus.dev_exec_o = 1'b0;
	assign bus.dev_exec_oe = pin_q[3];
	assign o_readdata = rdata_q;
	assign o_waitrequest = wreq_q;
	assign o_break = brk_q;
	assign o_exec_run = exrun_q;
	assign o_trace_started = tstart_q;
endmodule : cct_dev

// >>> verilog/cct_far.sv
// Far party on the shared trigger bus: another emulator or instrument.
// Assumes the same clock as the device; user requests are levels.
`timescale 1ns/100ps
module cct_far (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_ce,
	cct_if.far bus,
	input wire logic i_trig_req,
	input wire logic i_bnc_req,
	input wire logic i_ready_hold,
	input wire logic i_exec_req,
	output logic o_trig,
	output logic o_bnc,
	output logic o_ready,
	output logic o_exec
);
	logic [3:0] drv_q, drv_d;
	logic [3:0] s1_q, s2_q, s1_d;
	logic exec_prev_q;
	logic [3:0] out_q, out_d;

	// Drive and sample values
	always_comb begin
		drv_d = {i_exec_req, i_ready_hold, i_bnc_req, i_trig_req};
		s1_d = {~bus.exec_n, bus.ready, ~bus.bnc_trig_n, ~bus.trig_n};
		out_d = {s2_q[3] & ~exec_prev_q, s2_q[2:0]};
	end

	// Registered drive, two-stage sampling, edge of execute
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			drv_q <= 4'h0;
			s1_q <= 4'h4;
			s2_q <= 4'h4;
			exec_prev_q <= 1'b0;
			out_q <= 4'h4;
		end else if (i_ce) begin
			drv_q <= drv_d;
			s1_q <= s1_d;
			s2_q <= s1_q;
			exec_prev_q <= s2_q[3];
			out_q <= out_d;
		end
	end

	// Lines are pulled low only: trigger and execute low-true
	assign bus.far_trig_o = 1'b0;
	assign bus.far_trig_oe = drv_q[0];
	assign bus.far_bnc_o = 1'b0;
	assign bus.far_bnc_oe = drv_q[1];
	// Ready is high-true; holding it low stops an emulator with run control and background monitor on
	assign bus.far_rdy_o = 1'b0;
	assign bus.far_rdy_oe = drv_q[2];
	assign bus.far_exec_o = 1'b0;
	assign bus.far_exec_oe = drv_q[3];
	assign o_trig = out_q[0];
	assign o_bnc = out_q[1];
	assign o_ready = out_q[2];
	assign o_exec = out_q[3];
endmodule : cct_far

// >>> verilog/cct_if.sv
// Shared trigger bus and coaxial trigger line between two ends.
// Each party drives lines open-drain; the wire level is resolved here.
`timescale 1ns/100ps
interface cct_if;
	logic dev_trig_o, dev_trig_oe, far_trig_o, far_trig_oe;
	logic dev_bnc_o, dev_bnc_oe, far_bnc_o, far_bnc_oe;
	logic dev_rdy_o, dev_rdy_oe, far_rdy_o, far_rdy_oe;
	logic dev_exec_o, dev_exec_oe, far_exec_o, far_exec_oe;
	logic trig_n, bnc_trig_n, ready, exec_n;
	// Wired levels, pulled up when nobody drives
	assign trig_n = (dev_trig_oe ? dev_trig_o : 1'b1)
		& (far_trig_oe ? far_trig_o : 1'b1);
	assign bnc_trig_n = (dev_bnc_oe ? dev_bnc_o : 1'b1)
		& (far_bnc_oe ? far_bnc_o : 1'b1);
	assign ready = (dev_rdy_oe ? dev_rdy_o : 1'b1)
		& (far_rdy_oe ? far_rdy_o : 1'b1);
	assign exec_n = (dev_exec_oe ? dev_exec_o : 1'b1)
		& (far_exec_oe ? far_exec_o : 1'b1);
	modport dev (
		output dev_trig_o, dev_trig_oe, dev_bnc_o, dev_bnc_oe,
		output dev_rdy_o, dev_rdy_oe, dev_exec_o, dev_exec_oe,
		input trig_n, bnc_trig_n, ready, exec_n
	);
	modport far (
		output far_trig_o, far_trig_oe, far_bnc_o, far_bnc_oe,
		output far_rdy_o, far_rdy_oe, far_exec_o, far_exec_oe,
		input trig_n, bnc_trig_n, ready, exec_n
	);
endinterface : cct_if

// >>> verilog/cct_pkg.sv
// Shared constants and types for the coordinated cross-trigger logic.
// Assumes one 25 MHz system clock on both ends of the shared trigger bus.
package cct_pkg;
	// Clock and qualifier times
	localparam int CLK_NS = 40;
	localparam int RST_NS = 20;
	localparam int GT_MIN_NS = 30;
	localparam int GT_MAX_MS = 20;
	localparam int GT_STEP_NS = 10;
	localparam int LT_VALID_NS = 20;
	localparam int LT_MIN_NS = 40;
	localparam int LT_MAX_MS = 10;
	localparam int LT_STEP_NS = 20;
	localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int GT_MIN_CYC = (GT_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int GT_MAX_CYC = GT_MAX_MS * 1000000 / CLK_NS;
	localparam int LT_VALID_CYC = (LT_VALID_NS + CLK_NS - 1) / CLK_NS;
	localparam int LT_MIN_CYC = (LT_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int LT_MAX_CYC = LT_MAX_MS * 1000000 / CLK_NS;
	localparam int DUR_W = 20;
	// Register word offsets
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_ROUTE_A = 3'h1;
	localparam logic [2:0] REG_ROUTE_B = 3'h2;
	localparam logic [2:0] REG_PATTERN = 3'h3;
	localparam logic [2:0] REG_DURATION = 3'h4;
	localparam logic [2:0] REG_COMMAND = 3'h5;
	localparam logic [2:0] REG_STATUS = 3'h6;
	// Control fields
	localparam int CTL_RUNCTL = 0;
	localparam int CTL_EXEC = 1;
	localparam int CTL_BEGEXEC = 2;
	localparam int CTL_BGMON = 3;
	localparam int CTL_EXECRUN = 4;
	localparam int CTL_HOLDRDY = 5;
	localparam int CTL_W = 6;
	localparam logic [CTL_W-1:0] CTRL_RST = 6'h08;
	// Route fields, one route word per cross-trigger line
	localparam int RT_SRC_EMU = 0;
	localparam int RT_SRC_EXT = 1;
	localparam int RT_SRC_CMB = 2;
	localparam int RT_SRC_BNC = 3;
	localparam int RT_DST_BRK = 4;
	localparam int RT_DST_EMU = 5;
	localparam int RT_DST_EXT = 6;
	localparam int RT_DST_CMB = 7;
	localparam int RT_DST_BNC = 8;
	localparam int RT_W = 9;
	localparam logic [RT_W-1:0] ROUTE_RST = 9'h000;
	// Duration word: limit in cycles, mode bit selects less-than
	localparam int DUR_LT = 31;
	localparam logic [DUR_W-1:0] DUR_RST = 20'h00001;
	// Command bits, write-only
	localparam int CMD_EXT_BEGIN = 0;
	localparam int CMD_EXT_HALT = 1;
	localparam int CMD_EMU_BEGIN = 2;
	localparam int CMD_EMU_HALT = 3;
	localparam int CMD_RUN = 4;
	localparam int CMD_EXEC = 5;
	localparam int CMD_CLR = 6;
	// Synchroniser slots for the incoming bus lines
	localparam int LN_TRIG = 0;
	localparam int LN_BNC = 1;
	localparam int LN_RDY = 2;
	localparam int LN_EXEC = 3;
	localparam int N_LN = 4;
	// Timing qualifier states
	typedef enum logic [2:0] {
		TQ_IDLE, TQ_SEARCH, TQ_HOLD, TQ_WAITEND, TQ_RESET, TQ_DONE
	} cct_tq_state_t;
endpackage : cct_pkg
